// ==== tb_top.sv ====
// Purpose: Self-checking bench for the resource identification register bank.
// Assumes: Four parameter sets share one AXI4-Lite master; each instance answers in step.
// Notes: Expected words are built by hand from the field layout and the clamping choices.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Configurations and expected words
    // ************************************************************
    typedef struct packed {
        logic [11:0] addr;
        logic [1:0] resp;
        logic [3:0][31:0] data;
    } tridr_row_t;
    localparam logic [3:0] P_DVC [4] = '{4'h2, 4'hf, 4'h3, 4'h0};
    localparam logic P_DAC [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    localparam logic [3:0] P_ACP [4] = '{4'h2, 4'hf, 4'h1, 4'h0};
    localparam logic [3:0] P_RSP [4] = '{4'h4, 4'hf, 4'h0, 4'h1};
    localparam logic P_RED [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
    localparam logic [2:0] P_CNT [4] = '{3'h2, 3'h7, 3'h3, 3'h0};
    localparam logic [2:0] P_SEQ [4] = '{3'h4, 3'h2, 3'h4, 3'h0};
    localparam logic P_LPO [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    localparam logic P_LPM [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    localparam logic P_TRG [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    localparam logic [2:0] P_EXS [4] = '{3'h2, 3'h0, 3'h7, 3'h4};
    localparam logic [8:0] P_EXN [4] = '{9'h008, 9'h1ff, 9'h003, 9'h002};
    localparam logic P_VER [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    localparam logic [31:0] P_HI = 32'hfffff000;
    localparam logic [31:0] P_LO = 32'h00000fff;
    localparam tridr_row_t ROWS [5] = '{
        '{12'h000, tridr_pkg::RESP_OKAY, {32'h00010000, 32'h00000101, 32'h000f0182, 32'h00040022}},
        '{12'h004, tridr_pkg::RESP_OKAY, {32'h00870402, 32'h00c70000, 32'hc8070300, 32'h28c70408}},
        '{12'h008, tridr_pkg::RESP_OKAY, {32'h00000000, 32'h00000001, 32'h00000001, 32'h00000001}},
        '{12'h00c, tridr_pkg::RESP_SLVERR, {4{32'h00000000}}},
        '{12'hffc, tridr_pkg::RESP_SLVERR, {4{32'h00000000}}}};
    localparam logic [11:0] W_ADDR [3] = '{12'h000, 12'h004, 12'h010};
    localparam logic [1:0] W_RESP [3] = '{tridr_pkg::RESP_OKAY, tridr_pkg::RESP_OKAY, tridr_pkg::RESP_SLVERR};
    logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, exp_w;
    logic [3:0] wstrb, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp [4], rresp [4], got_r [4];
    logic [31:0] rdata [4], got_d [4];
    int num_errors = 0;
    int n_checks = 0;
    for (genvar g = 0; g < 4; g++) begin : g_cfg
        tridr_regs #(.DVC_COUNT(P_DVC[g]), .DAC_SUPPORTED(P_DAC[g]), .ACP_COUNT(P_ACP[g]), .RSP_COUNT(P_RSP[g]),
            .RED_COUNTER(P_RED[g]), .CNT_COUNT(P_CNT[g]), .SEQ_COUNT(P_SEQ[g]), .LPO_SUPPORTED(P_LPO[g]),
            .LOW_POWER_MODE(P_LPM[g]), .TRG_SUPPORTED(P_TRG[g]), .EXS_COUNT(P_EXS[g]), .EXN_COUNT(P_EXN[g]),
            .VERSION_43(P_VER[g])) i_dut (.I_MCLK(clk), .I_NRST(nrst),
            .I_AWVALID(awvalid), .O_AWREADY(awready[g]), .I_AWADDR(awaddr),
            .I_WVALID(wvalid), .O_WREADY(wready[g]), .I_WDATA(wdata), .I_WSTRB(wstrb),
            .O_BVALID(bvalid[g]), .I_BREADY(bready), .O_BRESP(bresp[g]),
            .I_ARVALID(arvalid), .O_ARREADY(arready[g]), .I_ARADDR(araddr),
            .O_RVALID(rvalid[g]), .I_RREADY(rready), .O_RDATA(rdata[g]), .O_RRESP(rresp[g]));
    end
    // ************************************************************
    // Compare and bus tasks
    // ************************************************************
    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_data
    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_resp
    task automatic cmp_flags(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_flags
    task automatic axi_read(input logic [11:0] addr);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= addr;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 4'hf);
        arvalid <= 1'b0;
        araddr <= ~addr;
        do @(posedge clk); while (rvalid !== 4'hf);
        got_d = rdata;
        got_r = rresp;
        rready <= 1'b0;
    endtask : axi_read
    task automatic axi_write(input logic [11:0] addr, input logic [31:0] data);
        bit aw_done;
        bit w_done;
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr <= addr;
        wvalid <= 1'b1;
        wdata <= data;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (!aw_done && awready === 4'hf) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
                awaddr <= ~addr;
            end
            if (!w_done && wready === 4'hf) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
                wdata <= ~data;
            end
        end
        do @(posedge clk); while (bvalid !== 4'hf);
        got_r = bresp;
        bready <= 1'b0;
    endtask : axi_write
    task automatic tally_and_finish();
        if (num_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (4000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        for (int pass = 0; pass < 2; pass++) begin
            repeat (4) @(posedge clk);
            cmp_flags(awready | wready | arready | bvalid | rvalid, 4'h0);
            nrst <= 1'b1;
            repeat (2) @(posedge clk);
            cmp_flags(awready | wready | arready, 4'h0);
            @(posedge clk);
            cmp_flags(awready & wready & arready, 4'hf);
            for (int w = 0; w < 3 && pass == 0; w++) begin
                axi_write(W_ADDR[w], 32'hffffffff);
                for (int i = 0; i < 4; i++) cmp_resp(got_r[i], W_RESP[w]);
            end
            for (int r = 0; r < 5; r++) begin
                axi_read(ROWS[r].addr);
                for (int i = 0; i < 4; i++) begin
                    exp_w = ROWS[r].data[i];
                    cmp_resp(got_r[i], ROWS[r].resp);
                    if (r == 0) cmp_data(got_d[i], exp_w);
                    if (r == 1) cmp_data(got_d[i] & P_HI, exp_w & P_HI);
                    if (r == 1) cmp_data(got_d[i] & P_LO, exp_w & P_LO);
                    if (r > 1) cmp_data(got_d[i], exp_w);
                end
            end
            @(posedge clk);
            nrst <= 1'b0;
        end
        tally_and_finish();
    end
endmodule : tb_top

// ==== tridr_pkg.sv ====
// Purpose: Constants for the trace resource identification register bank.
// Assumes: AXI4-Lite with 32-bit data; registers at byte offsets chosen for this bank.
// Notes: Field positions follow the identification register layouts.
package tridr_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [11:0] OFS_RESOURCE_ID_FOUR = 12'h000;
    localparam logic [11:0] OFS_RESOURCE_ID_FIVE = 12'h004;
    localparam logic [11:0] OFS_CONFIG_VERSION = 12'h008;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int POS_DVC = 4;
    localparam int POS_DAC = 8;
    localparam int POS_ACP = 0;
    localparam int POS_RSP = 16;
    localparam int POS_RED = 31;
    localparam int POS_CNT = 28;
    localparam int POS_SEQ = 25;
    localparam int POS_LPO = 23;
    localparam int POS_TRG = 22;
    localparam int POS_TID = 16;
    localparam int POS_EXS = 9;
    localparam int POS_EXN = 0;

    // ************************************************************
    // Limits and fixed values
    // ************************************************************
    localparam logic [3:0] MAX_DVC = 4'h8;
    localparam logic [3:0] MAX_ACP = 4'h2;
    localparam logic [2:0] MAX_CNT = 3'h4;
    localparam logic [2:0] SEQ_FOUR = 3'h4;
    localparam logic [2:0] MAX_EXS = 3'h4;
    localparam logic [8:0] MAX_EXN = 9'h100;
    localparam logic [8:0] FLAT_EXN = 9'h004;
    localparam logic [5:0] TRACE_ID_WIDTH = 6'h07;

    // ************************************************************
    // Bus response codes
    // ************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tridr_pkg

// ==== tridr_regs.sv ====
// Purpose: Read-only resource identification registers reached over AXI4-Lite.
// Assumes: Single clock I_MCLK at 40 MHz; I_NRST active low, asynchronous.
// Notes: Field values are parameters, clamped to the legal codes and their dependencies.
module tridr_regs #(
    parameter logic [3:0] DVC_COUNT = 4'h2,
    parameter logic DAC_SUPPORTED = 1'b0,
    parameter logic [3:0] ACP_COUNT = 4'h2,
    parameter logic [3:0] RSP_COUNT = 4'h4,
    parameter logic RED_COUNTER = 1'b0,
    parameter logic [2:0] CNT_COUNT = 3'h2,
    parameter logic [2:0] SEQ_COUNT = 3'h4,
    parameter logic LPO_SUPPORTED = 1'b1,
    parameter logic LOW_POWER_MODE = 1'b1,
    parameter logic TRG_SUPPORTED = 1'b1,
    parameter logic [2:0] EXS_COUNT = 3'h2,
    parameter logic [8:0] EXN_COUNT = 9'h008,
    parameter logic VERSION_43 = 1'b1
) (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_NRST,
    // Write address channel
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [11:0] I_AWADDR,
    // Write data channel
    input wire logic I_WVALID,
    output logic O_WREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    // Write response channel
    output logic O_BVALID,
    input wire logic I_BREADY,
    output logic [1:0] O_BRESP,
    // Read address channel
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    input wire logic [11:0] I_ARADDR,
    // Read data channel
    output logic O_RVALID,
    input wire logic I_RREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP
);
    // ************************************************************
    // State
    // ************************************************************
    // The reset synchroniser lives in the state; only its second stage is read.
    typedef struct packed {
        logic [1:0] rst_sync;
        logic aw_got;
        logic w_got;
        logic [11:0] aw_addr;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tridr_state_t;

    tridr_state_t st_r;
    tridr_state_t st_nxt;
    logic rst_n;
    assign rst_n = st_r.rst_sync[1];

    // ************************************************************
    // Legalised field values
    // ************************************************************
    logic rsp_zero;
    logic [3:0] dvc_v;
    logic [3:0] acp_v;
    logic [2:0] cnt_v;
    logic [2:0] seq_v;
    logic [2:0] exs_v;
    logic [8:0] exn_v;
    logic [2:0] exs_lim;
    logic lpo_v;
    logic [31:0] id_four;
    logic [31:0] id_five;

    assign rsp_zero = VERSION_43 && (RSP_COUNT == 4'h0);

    // Parameters are pushed onto legal codes here, so a wrong configuration
    // reports a legal value instead of a reserved code.
    // The order matters: the pair check zeroes the input count before the
    // selector limits look at it.
    always_comb begin
        dvc_v = (DVC_COUNT > tridr_pkg::MAX_DVC) ? tridr_pkg::MAX_DVC : DVC_COUNT;
        if (rsp_zero) begin
            dvc_v = 4'h0;
        end
        acp_v = (ACP_COUNT > tridr_pkg::MAX_ACP) ? tridr_pkg::MAX_ACP : ACP_COUNT;
        cnt_v = (CNT_COUNT > tridr_pkg::MAX_CNT) ? tridr_pkg::MAX_CNT : CNT_COUNT;
        seq_v = (SEQ_COUNT == 3'h0) ? 3'h0 : tridr_pkg::SEQ_FOUR;
        exn_v = (EXN_COUNT > tridr_pkg::MAX_EXN) ? tridr_pkg::MAX_EXN : EXN_COUNT;
        if (rsp_zero) begin
            cnt_v = 3'h0;
            seq_v = 3'h0;
            exn_v = 9'h000;
        end
        if (EXS_COUNT == 3'h0 && exn_v > tridr_pkg::FLAT_EXN) begin
            exs_v = 3'h1;
        end else begin
            exs_v = (EXS_COUNT > tridr_pkg::MAX_EXS) ? tridr_pkg::MAX_EXS : EXS_COUNT;
        end
        if (exn_v > tridr_pkg::FLAT_EXN && exs_v == 3'h0) begin
            exs_v = 3'h1;
        end
        exs_lim = (exn_v > 9'h004) ? 3'h4 : exn_v[2:0];
        if (exs_v > exs_lim) begin
            exs_v = exs_lim;
        end
        if (exn_v == 9'h000 || rsp_zero) begin
            exs_v = 3'h0;
        end
        lpo_v = LPO_SUPPORTED | LOW_POWER_MODE;
        id_four = 32'h0;
        id_four[tridr_pkg::POS_DVC +: 4] = dvc_v;
        id_four[tridr_pkg::POS_DAC] = DAC_SUPPORTED;
        id_four[tridr_pkg::POS_ACP +: 4] = acp_v;
        id_four[tridr_pkg::POS_RSP +: 4] = RSP_COUNT;
        id_five = 32'h0;
        id_five[tridr_pkg::POS_RED] = RED_COUNTER && (cnt_v != 3'h0);
        id_five[tridr_pkg::POS_CNT +: 3] = cnt_v;
        id_five[tridr_pkg::POS_SEQ +: 3] = seq_v;
        id_five[tridr_pkg::POS_LPO] = lpo_v;
        id_five[tridr_pkg::POS_TRG] = TRG_SUPPORTED;
        id_five[tridr_pkg::POS_TID +: 6] = tridr_pkg::TRACE_ID_WIDTH;
        id_five[tridr_pkg::POS_EXS +: 3] = exs_v;
        id_five[tridr_pkg::POS_EXN +: 9] = exn_v;
    end

    // ************************************************************
    // Bus slave
    // ************************************************************
    // Every register is read-only, so a write is taken, answered and dropped.
    // Its address is kept only to choose between OKAY and SLVERR.
    // A read is answered one cycle after its address is taken, and the next
    // address waits until the data have been taken, so one read at most is open.
    // The same holds for writes through the held flags and the response.
    logic aw_take;
    logic w_take;
    logic ar_take;
    assign O_AWREADY = rst_n && !st_r.aw_got && !st_r.bvalid;
    assign O_WREADY = rst_n && !st_r.w_got && !st_r.bvalid;
    assign O_ARREADY = rst_n && !st_r.rvalid;
    assign aw_take = I_AWVALID && O_AWREADY;
    assign w_take = I_WVALID && O_WREADY;
    assign ar_take = I_ARVALID && O_ARREADY;

    always_comb begin
        st_nxt = st_r;
        st_nxt.rst_sync = {st_r.rst_sync[0], 1'b1};
        if (aw_take) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.aw_addr = I_AWADDR;
        end
        if (w_take) begin
            st_nxt.w_got = 1'b1;
        end
        // Both halves are held for one cycle first, so the address compare
        // below reads registered state only.
        // Writes acknowledged with no effect.
        if (st_r.aw_got && st_r.w_got) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            if (st_r.aw_addr == tridr_pkg::OFS_RESOURCE_ID_FOUR ||
                st_r.aw_addr == tridr_pkg::OFS_RESOURCE_ID_FIVE ||
                st_r.aw_addr == tridr_pkg::OFS_CONFIG_VERSION) begin
                st_nxt.bresp = tridr_pkg::RESP_OKAY;
            end else begin
                st_nxt.bresp = tridr_pkg::RESP_SLVERR;
            end
        end
        if (st_r.bvalid && I_BREADY) begin
            st_nxt.bvalid = 1'b0;
        end
        if (ar_take) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = tridr_pkg::RESP_OKAY;
            case (I_ARADDR)
                tridr_pkg::OFS_RESOURCE_ID_FOUR: begin
                    st_nxt.rdata = id_four;
                end
                tridr_pkg::OFS_RESOURCE_ID_FIVE: begin
                    st_nxt.rdata = id_five;
                end
                tridr_pkg::OFS_CONFIG_VERSION: begin
                    st_nxt.rdata = {31'h0, VERSION_43};
                end
                default: begin
                    st_nxt.rdata = 32'h0;
                    st_nxt.rresp = tridr_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st_r.rvalid && I_RREADY) begin
            st_nxt.rvalid = 1'b0;
        end
    end

    // The reset clears the synchroniser too, so the readies stay low until
    // two edges have passed after the pin is released.
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Every answer on the bus comes straight from a register.
    assign O_BVALID = st_r.bvalid;
    assign O_BRESP = st_r.bresp;
    assign O_RVALID = st_r.rvalid;
    assign O_RDATA = st_r.rdata;
    assign O_RRESP = st_r.rresp;

    // ************************************************************
    // Checks
    // ************************************************************
    // The checks run on the bus clock and, except the two reset checks, rest while the synchronised reset is low.
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!rst_n);

    dvc_range_a: assert property (id_four[7:4] <= 4'h8) else $error("comparator count out of range");
    dvc_pairs_a: assert property (rsp_zero |-> id_four[7:4] == 4'h0) else $error("comparators with no pairs");
    dac_bit_a: assert property (id_four[8] == DAC_SUPPORTED) else $error("address support bit wrong");
    acp_range_a: assert property (id_four[3:0] <= 4'h2) else $error("address pairs out of range");
    red_bit_a: assert property (id_five[31] |-> id_five[30:28] != 3'h0) else $error("reduced counter without counter");
    cnt_range_a: assert property (id_five[30:28] <= 3'h4) else $error("counter count out of range");
    res_zero_a: assert property (rsp_zero |-> id_five[30:25] == 6'h0 && id_five[11:0] == 12'h0)
        else $error("resources with no pairs");
    seq_code_a: assert property (id_five[27:25] == 3'h0 || id_five[27:25] == 3'h4) else $error("bad sequencer code");
    lpo_bit_a: assert property (LOW_POWER_MODE |-> id_five[23]) else $error("override not reported");
    tid_width_a: assert property (id_five[21:16] == 6'h07) else $error("trace id width wrong");
    exs_range_a: assert property (id_five[11:9] <= 3'h4) else $error("selector count out of range");
    exs_bound_a: assert property ({6'h0, id_five[11:9]} <= id_five[8:0]) else $error("selectors exceed inputs");
    exn_range_a: assert property (id_five[8:0] <= 9'h100) else $error("input count out of range");
    exn_sel_a: assert property (id_five[8:0] > 9'h004 |-> id_five[11:9] != 3'h0) else $error("no selector for inputs");
    flat_map_a: assert property (id_five[11:9] == 3'h0 |-> id_five[8:0] <= 9'h004) else $error("flat map too wide");
    res_bits_a: assert property (id_five[24] == 1'b0 && id_five[15:12] == 4'h0) else $error("reserved bits set");
    rd_answer_a: assert property (ar_take && I_ARADDR == tridr_pkg::OFS_RESOURCE_ID_FIVE |=>
        O_RVALID && O_RDATA == id_five)
        else $error("read of fifth register wrong");
    wr_resp_a: assert property (st_r.aw_got && st_r.w_got |=> O_BVALID) else $error("write not answered");

    // ************************************************************
    // Field value checks
    // ************************************************************
    // A parameter inside its legal range must come through unchanged.
    dvc_exact_a: assert property (!rsp_zero && DVC_COUNT <= 4'h8 |-> id_four[7:4] == DVC_COUNT)
        else $error("comparator count altered");
    acp_exact_a: assert property (ACP_COUNT <= 4'h2 |-> id_four[3:0] == ACP_COUNT)
        else $error("address pair count altered");
    cnt_exact_a: assert property (!rsp_zero && CNT_COUNT <= 3'h4 |-> id_five[30:28] == CNT_COUNT)
        else $error("counter count altered");
    exn_exact_a: assert property (!rsp_zero && EXN_COUNT <= 9'h100 |-> id_five[8:0] == EXN_COUNT)
        else $error("input count altered");
    exs_exact_a: assert property (EXS_COUNT != 3'h0 && EXS_COUNT <= 3'h4 &&
        {6'h0, EXS_COUNT} <= id_five[8:0] |-> id_five[11:9] == EXS_COUNT)
        else $error("selector count altered");
    seq_four_a: assert property (!rsp_zero && SEQ_COUNT != 3'h0 |-> id_five[27:25] == 3'h4)
        else $error("sequencer states lost");
    seq_none_a: assert property (SEQ_COUNT == 3'h0 |-> id_five[27:25] == 3'h0)
        else $error("sequencer states invented");

    // A parameter above its range must land on the top legal code, and a zero selector count with more than four inputs on one.
    dvc_clamp_a: assert property (!rsp_zero && DVC_COUNT > 4'h8 |-> id_four[7:4] == 4'h8)
        else $error("comparator count not clamped");
    acp_clamp_a: assert property (ACP_COUNT > 4'h2 |-> id_four[3:0] == 4'h2)
        else $error("address pair count not clamped");
    cnt_clamp_a: assert property (!rsp_zero && CNT_COUNT > 3'h4 |-> id_five[30:28] == 3'h4)
        else $error("counter count not clamped");
    exn_clamp_a: assert property (!rsp_zero && EXN_COUNT > 9'h100 |-> id_five[8:0] == 9'h100)
        else $error("input count not clamped");
    exs_one_a: assert property (!rsp_zero && EXS_COUNT == 3'h0 && id_five[8:0] > 9'h004 |-> id_five[11:9] == 3'h1)
        else $error("selector not added");

    // Flags and fixed fields.
    rsp_field_a: assert property (id_four[19:16] == RSP_COUNT)
        else $error("resource pair field wrong");
    four_res_a: assert property (id_four[31:20] == 12'h000 && id_four[15:9] == 7'h00)
        else $error("reserved bits of fourth register set");
    red_flag_a: assert property (RED_COUNTER && id_five[30:28] != 3'h0 |-> id_five[31])
        else $error("reduced counter not reported");
    red_none_a: assert property (!RED_COUNTER |-> !id_five[31])
        else $error("reduced counter invented");
    lpo_only_a: assert property (id_five[23] |-> LPO_SUPPORTED || LOW_POWER_MODE)
        else $error("override reported without support");
    lpo_kept_a: assert property (LPO_SUPPORTED |-> id_five[23])
        else $error("override support not reported");
    trg_bit_a: assert property (id_five[22] == TRG_SUPPORTED)
        else $error("bus trigger bit wrong");
    exn_zero_a: assert property (id_five[8:0] == 9'h000 |-> id_five[11:9] == 3'h0)
        else $error("selectors with no inputs");

    // ************************************************************
    // Bus checks
    // ************************************************************
    // The readies must stay low until the reset synchroniser has let go.
    rst_ready_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        !rst_n |-> !O_AWREADY && !O_WREADY && !O_ARREADY)
        else $error("ready raised during reset");
    rst_quiet_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
        !rst_n |-> !O_BVALID && !O_RVALID)
        else $error("answer raised during reset");
    ar_block_a: assert property (O_RVALID |-> !O_ARREADY)
        else $error("read address taken while data pending");
    rd_drop_a: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
        else $error("read data held after it was taken");
    rd_four_a: assert property (ar_take && I_ARADDR == tridr_pkg::OFS_RESOURCE_ID_FOUR |=>
        O_RVALID && O_RDATA == id_four && O_RRESP == tridr_pkg::RESP_OKAY)
        else $error("read of fourth register wrong");
    ver_read_a: assert property (ar_take && I_ARADDR == tridr_pkg::OFS_CONFIG_VERSION |=>
        O_RVALID && O_RDATA == {31'h0, VERSION_43})
        else $error("read of version word wrong");
    rd_err_a: assert property (ar_take && I_ARADDR > tridr_pkg::OFS_CONFIG_VERSION |=>
        O_RRESP == tridr_pkg::RESP_SLVERR && O_RDATA == 32'h0)
        else $error("unmapped read not refused");
    aw_block_a: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
        else $error("write taken while response pending");
    b_drop_a: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
        else $error("write response held after it was taken");
    wr_ok_a: assert property (st_r.aw_got && st_r.w_got &&
        st_r.aw_addr == tridr_pkg::OFS_RESOURCE_ID_FIVE |=> O_BRESP == tridr_pkg::RESP_OKAY)
        else $error("mapped write refused");
    wr_err_a: assert property (st_r.aw_got && st_r.w_got &&
        st_r.aw_addr > tridr_pkg::OFS_CONFIG_VERSION |=> O_BRESP == tridr_pkg::RESP_SLVERR)
        else $error("unmapped write accepted");
endmodule : tridr_regs
